// [cfg_seq_pkg.sv]
// package: tap states, instruction codes, widths and tck counts for the start-up sequencer
package cfg_seq_pkg;
    // instruction register length (per-device; longer on stacked multi-die parts)
    localparam int IR_LEN = 6;
    // configuration data word width
    localparam int WORD_W = 32;
    // buffer depth between the tck side and the user side
    localparam int BUF_DEPTH = 2;

    // instruction codes (shifted lsb first)
    localparam logic [IR_LEN-1:0] INSTR_STARTUP = 6'h0c; // startup_trigger_instr
    localparam logic [IR_LEN-1:0] INSTR_CLEAR = 6'h0b; // config_clear_instr
    localparam logic [IR_LEN-1:0] INSTR_SHUTDOWN = 6'h0d; // shutdown_instr
    localparam logic [IR_LEN-1:0] INSTR_CFG_IN = 6'h05;
    localparam logic [IR_LEN-1:0] INSTR_BYPASS = 6'h3f;
    localparam logic [IR_LEN-1:0] IR_RESET = INSTR_BYPASS;

    // captured instruction-register pattern and its status bit positions
    localparam logic [IR_LEN-1:0] IR_CAPTURE_PAT = 6'h01;
    localparam int IR_INIT_BIT = 2;
    localparam int IR_DONE_BIT = 3;

    // tck counts
    localparam logic [10:0] STARTUP_TCKS = 11'h7d0; // 2000 clocks in run-test/idle
    localparam logic [7:0] CLEAR_TCKS = 8'h40; // tck cycles to finish a clear
    localparam int STARTUP_WAIT_MS = 10; // host wait at idle, at 1 MHz tck
    localparam logic [4:0] WORD_LAST_BIT = 5'h1f;

    // reset values
    localparam logic INIT_DONE_RST = 1'b1;

    // tap controller states, gray along the usual path
    typedef enum logic [3:0] {
        TAP_TLR = 4'h0,
        TAP_RTI = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6,
        TAP_EX1_DR = 4'h7,
        TAP_PAUSE_DR = 4'h5,
        TAP_EX2_DR = 4'h4,
        TAP_UPD_DR = 4'hc,
        TAP_SEL_IR = 4'hd,
        TAP_CAP_IR = 4'hf,
        TAP_SHIFT_IR = 4'he,
        TAP_EX1_IR = 4'ha,
        TAP_PAUSE_IR = 4'hb,
        TAP_EX2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } tap_state_t;
endpackage

// [cfg_word_buffer.sv]
// module: two-entry word buffer with registered head, honest full and empty
`timescale 1ns/1ns
module cfg_word_buffer
(
    input wire logic clock,
    input wire logic sys_rst,
    cfg_word_if.buffer bus
);
    import cfg_seq_pkg::*;

    logic headValid_r, headValid_nxt;
    logic tailValid_r, tailValid_nxt;
    logic [WORD_W-1:0] headData_r, headData_nxt;
    logic [WORD_W-1:0] tailData_r, tailData_nxt;
    logic doPush;
    logic doPop;

    ////////////////////////////////////////////////////////////////////////////
    // the head slot drives the output, so the user side sees flop outputs only
    assign bus.popValid = headValid_r;
    assign bus.popData = headData_r;
    // full only when both slots hold a word
    assign bus.pushReady = !tailValid_r;
    assign doPush = bus.pushValid && !tailValid_r;
    assign doPop = headValid_r && bus.popReady;

    // pop first moves the tail forward, then a push fills the first free slot
    always_comb
    begin
        headValid_nxt = headValid_r;
        headData_nxt = headData_r;
        tailValid_nxt = tailValid_r;
        tailData_nxt = tailData_r;
        if (doPop)
        begin
            headValid_nxt = tailValid_r;
            headData_nxt = tailData_r;
            tailValid_nxt = 1'b0;
        end
        if (doPush)
        begin
            if (!headValid_nxt)
            begin
                headValid_nxt = 1'b1;
                headData_nxt = bus.pushData;
            end
            else
            begin
                tailValid_nxt = 1'b1;
                tailData_nxt = bus.pushData;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            headValid_r <= 1'b0;
            tailValid_r <= 1'b0;
            headData_r <= '0;
            tailData_r <= '0;
        end
        else
        begin
            headValid_r <= headValid_nxt;
            tailValid_r <= tailValid_nxt;
            headData_r <= headData_nxt;
            tailData_r <= tailData_nxt;
        end
    end
endmodule // cfg_word_buffer

// [cfg_word_if.sv]
// interface: word stream between the crossing logic and the two-entry buffer
`timescale 1ns/1ns
interface cfg_word_if;
    logic pushValid;
    logic pushReady;
    logic [cfg_seq_pkg::WORD_W-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [cfg_seq_pkg::WORD_W-1:0] popData;

    modport buffer (input pushValid, input pushData, input popReady,
                    output pushReady, output popValid, output popData);
    modport user (output pushValid, output pushData, output popReady,
                  input pushReady, input popValid, input popData);
endinterface

// [jtag_config_start_sequencer.sv]
// module: device-side tap with instruction decode, config shift, start-up and clear sequencing
`timescale 1ns/1ns
// Functional notes
// - run-test/idle with start-up loaded: 2000 tck clocks run the start-up sequence
// - three tms=1 clocks reach test-logic-reset; device is then operational (here only on the next tck in test-logic-reset)
// - configuration data enters at tdi, moves toward tdo, msb first
// - instruction register length is device specific
module jtag_config_start_sequencer
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    output logic [cfg_seq_pkg::WORD_W-1:0] cfgData,
    output logic cfgValid,
    input wire logic cfgReady,
    output logic devOperational,
    output logic cfgOverrun
);
    import cfg_seq_pkg::*;

    // tck domain state
    tap_state_t tapState_r, tapState_nxt;
    logic [IR_LEN-1:0] ir_r, ir_nxt;
    logic [IR_LEN-1:0] irShift_r, irShift_nxt;
    logic [WORD_W-1:0] drShift_r, drShift_nxt;
    logic [WORD_W-1:0] wordHold_r, wordHold_nxt;
    logic [4:0] bitCnt_r, bitCnt_nxt;
    logic [10:0] startCnt_r, startCnt_nxt;
    logic [7:0] clearCnt_r, clearCnt_nxt;
    logic bypass_r, bypass_nxt;
    logic startupDone_r, startupDone_nxt;
    logic operational_r, operational_nxt;
    logic initDone_r, initDone_nxt;
    logic overrun_r, overrun_nxt;
    logic wordTgl_r, wordTgl_nxt;
    logic [2:0] ackSync_r, ackSync_nxt;
    logic ackSeen_r, ackSeen_nxt;
    logic tdo_r, tdoEn_r, tdoNxt, tdoEnNxt;
    logic cfgSel, wordDone, wordPending;
    logic [IR_LEN-1:0] irCapture;
    // clock domain state
    logic [2:0] wordSync_r, wordSync_nxt;
    logic [2:0] opSync_r, opSync_nxt;
    logic [2:0] ovSync_r, ovSync_nxt;
    logic wordSeen_r, wordSeen_nxt;
    logic devOperational_r, devOperational_nxt;
    logic cfgOverrun_r, cfgOverrun_nxt;
    logic newWord;

    cfg_word_if wordBus();

    ////////////////////////////////////////////////////////////////////////////
    // tap controller next state, walked by tms on each rising tck
    always_comb
    begin
        tapState_nxt = tapState_r;
        case (tapState_r)
            TAP_TLR: tapState_nxt = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: tapState_nxt = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tapState_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tapState_nxt = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapState_nxt = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_EX1_DR: tapState_nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapState_nxt = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR: tapState_nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tapState_nxt = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tapState_nxt = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tapState_nxt = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapState_nxt = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_EX1_IR: tapState_nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapState_nxt = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR: tapState_nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tapState_nxt = tms ? TAP_SEL_DR : TAP_RTI;
            default: tapState_nxt = TAP_TLR;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // a configured device keeps config-in on the bypass path until cleared or shut down
    assign cfgSel = (ir_r == INSTR_CFG_IN) && !operational_r;
    assign wordDone = (tapState_r == TAP_SHIFT_DR) && cfgSel && (bitCnt_r == WORD_LAST_BIT);
    // the held word is stable until the clock side acknowledges it
    assign wordPending = (wordTgl_r != ackSeen_r);

    // captured ir shows start-up done and init status for the host to poll
    always_comb
    begin
        irCapture = IR_CAPTURE_PAT;
        irCapture[IR_DONE_BIT] = startupDone_r;
        irCapture[IR_INIT_BIT] = initDone_r;
    end

    // instruction and data registers, start-up and clear sequencing
    always_comb
    begin
        ir_nxt = ir_r;
        irShift_nxt = irShift_r;
        drShift_nxt = drShift_r;
        wordHold_nxt = wordHold_r;
        bitCnt_nxt = bitCnt_r;
        startCnt_nxt = startCnt_r;
        clearCnt_nxt = clearCnt_r;
        bypass_nxt = bypass_r;
        startupDone_nxt = startupDone_r;
        operational_nxt = operational_r;
        initDone_nxt = initDone_r;
        overrun_nxt = overrun_r;
        wordTgl_nxt = wordTgl_r;
        case (tapState_r)
            TAP_TLR: ir_nxt = IR_RESET;
            TAP_CAP_IR: irShift_nxt = irCapture;
            // full-length shift keeps every device length honest in a chain
            TAP_SHIFT_IR: irShift_nxt = {tdi, irShift_r[IR_LEN-1:1]};
            TAP_UPD_IR:
            begin
                ir_nxt = irShift_r;
                startCnt_nxt = '0;
            end
            TAP_CAP_DR:
            begin
                bypass_nxt = 1'b0;
                bitCnt_nxt = '0;
            end
            TAP_SHIFT_DR:
            begin
                if (cfgSel)
                begin
                    drShift_nxt = {drShift_r[WORD_W-2:0], tdi};
                    bitCnt_nxt = bitCnt_r + 5'h1;
                end
                else
                begin
                    bypass_nxt = tdi;
                end
            end
            default: ;
        endcase
        // one word per 32 shifted bits; a word arriving while one is unacked is lost
        if (wordDone)
        begin
            if (wordPending)
            begin
                overrun_nxt = 1'b1;
            end
            else
            begin
                wordHold_nxt = {drShift_r[WORD_W-2:0], tdi};
                wordTgl_nxt = !wordTgl_r;
            end
        end
        // start-up clocks count only in run-test/idle with start-up loaded
        if (tapState_r == TAP_RTI && ir_r == INSTR_STARTUP && !startupDone_r)
        begin
            startCnt_nxt = startCnt_r + 11'h1;
            if (startCnt_r == STARTUP_TCKS - 11'h1)
            begin
                startupDone_nxt = 1'b1;
            end
        end
        // operational once test-logic-reset is reached after start-up
        if (tapState_r == TAP_TLR && startupDone_r)
        begin
            operational_nxt = 1'b1;
        end
        if (tapState_r == TAP_RTI && ir_r == INSTR_SHUTDOWN)
        begin
            operational_nxt = 1'b0;
            startupDone_nxt = 1'b0;
        end
        // clear wipes state; init rises again after the clear has run its course
        if (!initDone_r)
        begin
            clearCnt_nxt = clearCnt_r + 8'h1;
            if (clearCnt_r == CLEAR_TCKS - 8'h1)
            begin
                initDone_nxt = 1'b1;
            end
        end
        if (tapState_r == TAP_UPD_IR && irShift_r == INSTR_CLEAR)
        begin
            initDone_nxt = 1'b0;
            clearCnt_nxt = '0;
            startupDone_nxt = 1'b0;
            operational_nxt = 1'b0;
            overrun_nxt = 1'b0;
        end
        // three-flop ack sync; the first flop feeds only the second
        ackSync_nxt = {ackSync_r[1:0], wordSeen_r};
        ackSeen_nxt = (ackSync_r[1] == ackSync_r[2]) ? ackSync_r[2] : ackSeen_r;
        // tdo follows the selected register's outgoing end
        tdoEnNxt = (tapState_r == TAP_SHIFT_IR) || (tapState_r == TAP_SHIFT_DR);
        if (tapState_r == TAP_SHIFT_IR)
        begin
            tdoNxt = irShift_r[0];
        end
        else if (cfgSel)
        begin
            tdoNxt = drShift_r[WORD_W-1];
        end
        else
        begin
            tdoNxt = bypass_r;
        end
    end

    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tapState_r <= TAP_TLR;
            ir_r <= IR_RESET;
            irShift_r <= '0;
            drShift_r <= '0;
            wordHold_r <= '0;
            bitCnt_r <= '0;
            startCnt_r <= '0;
            clearCnt_r <= '0;
            bypass_r <= 1'b0;
            startupDone_r <= 1'b0;
            operational_r <= 1'b0;
            initDone_r <= INIT_DONE_RST;
            overrun_r <= 1'b0;
            wordTgl_r <= 1'b0;
            ackSync_r <= '0;
            ackSeen_r <= 1'b0;
        end
        else
        begin
            tapState_r <= tapState_nxt;
            ir_r <= ir_nxt;
            irShift_r <= irShift_nxt;
            drShift_r <= drShift_nxt;
            wordHold_r <= wordHold_nxt;
            bitCnt_r <= bitCnt_nxt;
            startCnt_r <= startCnt_nxt;
            clearCnt_r <= clearCnt_nxt;
            bypass_r <= bypass_nxt;
            startupDone_r <= startupDone_nxt;
            operational_r <= operational_nxt;
            initDone_r <= initDone_nxt;
            overrun_r <= overrun_nxt;
            wordTgl_r <= wordTgl_nxt;
            ackSync_r <= ackSync_nxt;
            ackSeen_r <= ackSeen_nxt;
        end
    end

    // tdo changes on the falling edge so the host samples it on the next rise
    always_ff @(negedge tck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tdo_r <= 1'b0;
            tdoEn_r <= 1'b0;
        end
        else
        begin
            tdo_r <= tdoNxt;
            tdoEn_r <= tdoEnNxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock domain: word toggle, status levels and the buffer push
    assign newWord = (wordSync_r[1] == wordSync_r[2]) && (wordSync_r[2] != wordSeen_r);
    assign wordBus.pushValid = newWord;
    assign wordBus.pushData = wordHold_r; // held stable by the tck side until acked
    assign wordBus.popReady = cfgReady;

    always_comb
    begin
        wordSync_nxt = {wordSync_r[1:0], wordTgl_r};
        opSync_nxt = {opSync_r[1:0], operational_r};
        ovSync_nxt = {ovSync_r[1:0], overrun_r};
        // a full buffer leaves the word unacked, so the tck side drops the next word as an overrun
        wordSeen_nxt = (newWord && wordBus.pushReady) ? wordSync_r[2] : wordSeen_r;
        devOperational_nxt = (opSync_r[1] == opSync_r[2]) ? opSync_r[2] : devOperational_r;
        cfgOverrun_nxt = (ovSync_r[1] == ovSync_r[2]) ? ovSync_r[2] : cfgOverrun_r;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wordSync_r <= '0;
            opSync_r <= '0;
            ovSync_r <= '0;
            wordSeen_r <= 1'b0;
            devOperational_r <= 1'b0;
            cfgOverrun_r <= 1'b0;
        end
        else
        begin
            wordSync_r <= wordSync_nxt;
            opSync_r <= opSync_nxt;
            ovSync_r <= ovSync_nxt;
            wordSeen_r <= wordSeen_nxt;
            devOperational_r <= devOperational_nxt;
            cfgOverrun_r <= cfgOverrun_nxt;
        end
    end

    cfg_word_buffer uBuffer
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus(wordBus.buffer)
    );

    assign tdo = tdo_r;
    assign tdoEn = tdoEn_r;
    assign cfgData = wordBus.popData;
    assign cfgValid = wordBus.popValid;
    assign devOperational = devOperational_r;
    assign cfgOverrun = cfgOverrun_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the tck side
    a_shift_ir_entry: assert property (@(posedge tck) disable iff (sys_rst)
        (tapState_r == TAP_SEL_IR && !tms) ##1 !tms |=> tapState_r == TAP_SHIFT_IR)
        else $error("two tms low clocks from select-ir did not reach shift-ir");
    a_ir_lsb_first: assert property (@(posedge tck) disable iff (sys_rst)
        tapState_r == TAP_SHIFT_IR |=> irShift_r[IR_LEN-1] == $past(tdi) && irShift_r[0] == $past(irShift_r[1]))
        else $error("instruction shift is not lsb first");
    a_update_ir_load: assert property (@(posedge tck) disable iff (sys_rst)
        tapState_r == TAP_UPD_IR |=> ir_r == $past(irShift_r))
        else $error("update-ir did not load the shifted instruction");
    a_dr_msb_first: assert property (@(posedge tck) disable iff (sys_rst)
        tapState_r == TAP_SHIFT_DR && cfgSel |=> drShift_r[0] == $past(tdi) && drShift_r[1] == $past(drShift_r[0]))
        else $error("config data does not move toward tdo msb first");
    a_startup_done: assert property (@(posedge tck) disable iff (sys_rst)
        $rose(startupDone_r) |-> $past(tapState_r) == TAP_RTI && $past(ir_r) == INSTR_STARTUP
        && $past(startCnt_r) == STARTUP_TCKS - 11'h1)
        else $error("start-up done without 2000 idle clocks");
    a_operational_tlr: assert property (@(posedge tck) disable iff (sys_rst)
        startupDone_r && tapState_r == TAP_TLR && ir_r != INSTR_SHUTDOWN |=> operational_r)
        else $error("device not operational after reaching test-logic-reset");
    a_tlr_five_ones: assert property (@(posedge tck) disable iff (sys_rst)
        tms [*5] |=> tapState_r == TAP_TLR && ir_nxt == IR_RESET)
        else $error("five tms high clocks did not reset the tap");
    a_config_locked: assert property (@(posedge tck) disable iff (sys_rst)
        operational_r && tapState_r == TAP_SHIFT_DR |=> drShift_r == $past(drShift_r))
        else $error("configured device accepted config data");
    a_clear_init: assert property (@(posedge tck) disable iff (sys_rst)
        tapState_r == TAP_UPD_IR && irShift_r == INSTR_CLEAR |=> !initDone_r && !operational_r)
        else $error("clear did not drop init and operational");
    // the enable set at one falling tck reflects the state seen at that fall
    a_tdo_drive: assert property (@(negedge tck) disable iff (sys_rst)
        tdoEn_r == ($past(tapState_r) == TAP_SHIFT_IR || $past(tapState_r) == TAP_SHIFT_DR))
        else $error("tdo enable does not follow the shift states");
    // checks on the clock side
    a_push_held: assert property (@(posedge clock) disable iff (sys_rst)
        wordBus.pushValid && !wordBus.pushReady |=> wordBus.pushValid && $stable(wordBus.pushData))
        else $error("stalled word dropped or changed before the buffer took it");

    c_startup_run: cover property (@(posedge tck) disable iff (sys_rst) $rose(startupDone_r));
    c_operational: cover property (@(posedge clock) disable iff (sys_rst) $rose(devOperational_r));
    c_buffer_full: cover property (@(posedge clock) disable iff (sys_rst) cfgValid && !wordBus.pushReady);
    c_clear_seen: cover property (@(posedge tck) disable iff (sys_rst) $rose(initDone_r));
endmodule // jtag_config_start_sequencer

// [jtag_config_start_sequencer_tb.sv]
// testbench: host model drives the tap, a word queue predicts the user stream
`timescale 1ns/1ns
module jtag_config_start_sequencer_tb;
    import cfg_seq_pkg::*;
    logic clock, sys_rst, tck, tms, tdi, tdo, tdoEn, cfgValid, cfgReady, devOperational, cfgOverrun, stall;
    logic [WORD_W-1:0] cfgData;
    logic [IR_LEN-1:0] cap;
    logic [WORD_W-1:0] expWords[$];
    integer seed = 32'h0320;
    int failures = 0;
    int compares = 0;
    int tries;
    ////////////////////////////////////////
    jtag_config_start_sequencer jtag_config_start_sequencer_i (.clock(clock), .sys_rst(sys_rst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .cfgData(cfgData), .cfgValid(cfgValid),
        .cfgReady(cfgReady), .devOperational(devOperational), .cfgOverrun(cfgOverrun));
    jtag_host_model jtag_host_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one random word; keep=0 marks a word the device must drop
    task automatic sendWord(input bit keep);
        logic [WORD_W-1:0] w;
        w = $random(seed);
        if (keep)
            expWords.push_back(w);
        jtag_host_model_i.dr(w);
    endtask
    ////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // random user stalls; every handshake is matched against the queue
    always @(posedge clock)
    begin
        cfgReady <= stall ? 1'b0 : 1'($random(seed));
        if (cfgValid === 1'b1 && cfgReady === 1'b1)
        begin
            if (expWords.size() == 0)
                chk(WORD_W'(cfgValid), '0);
            else
                chk(cfgData, expWords.pop_front());
        end
    end
    // whole run is about 77 us; far beyond that means a hang
    initial
    begin
        #200000;
        failures++;
        tally_and_finish;
    end
    ////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        cfgReady = 1'b0;
        stall = 1'b0;
        jtag_host_model_i.walk(1'b1, 1);
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        jtag_host_model_i.walk(1'b1, 5);
        jtag_host_model_i.walk(1'b0, 1);
        jtag_host_model_i.ir(INSTR_CFG_IN, cap);
        chk(WORD_W'(cap), WORD_W'(IR_CAPTURE_PAT | (1 << IR_INIT_BIT)));
        chk(WORD_W'(tdoEn), '0);
        repeat (3) sendWord(1'b1);
        repeat (60) @(posedge clock);
        chk(WORD_W'(expWords.size()), '0);
        chk(WORD_W'(devOperational), '0);
        // user held off: two words buffered, one waits at the crossing, the fourth is lost
        stall <= 1'b1;
        repeat (3) sendWord(1'b1);
        chk(WORD_W'(cfgOverrun), '0);
        sendWord(1'b0);
        repeat (20) @(posedge clock);
        chk(WORD_W'(cfgOverrun), 1);
        stall <= 1'b0;
        repeat (60) @(posedge clock);
        chk(WORD_W'(expWords.size()), '0);
        // clear, then poll bypass until init returns after the clear count
        jtag_host_model_i.ir(INSTR_CLEAR, cap);
        jtag_host_model_i.ir(INSTR_BYPASS, cap);
        chk(WORD_W'(cap[IR_INIT_BIT]), '0);
        chk(WORD_W'(cfgOverrun), '0);
        tries = 0;
        while (cap[IR_INIT_BIT] !== 1'b1 && tries < 20)
        begin
            jtag_host_model_i.ir(INSTR_BYPASS, cap);
            tries++;
        end
        // each load is 12 tck; capture k sees init as it stood 3 + 12k tck after the clear
        chk(WORD_W'(tries), WORD_W'((int'(CLEAR_TCKS) + 8) / 12));
        jtag_host_model_i.ir(INSTR_CFG_IN, cap);
        sendWord(1'b1);
        // start-up: idle clocks, not operational until test-logic-reset
        jtag_host_model_i.ir(INSTR_STARTUP, cap);
        jtag_host_model_i.walk(1'b0, STARTUP_TCKS);
        // idle wait with tck stopped, scaled from a 1 us tck to the 6 ns bench tck
        #(STARTUP_WAIT_MS * 6000);
        repeat (10) @(posedge clock);
        chk(WORD_W'(devOperational), '0);
        jtag_host_model_i.walk(1'b1, 4);
        repeat (10) @(posedge clock);
        chk(WORD_W'(devOperational), 1);
        chk(WORD_W'(expWords.size()), '0);
        // data sent while operational must vanish, then shutdown drops operational
        jtag_host_model_i.walk(1'b0, 1);
        jtag_host_model_i.ir(INSTR_CFG_IN, cap);
        sendWord(1'b0);
        jtag_host_model_i.ir(INSTR_SHUTDOWN, cap);
        // shutdown acts on a tck that finds run-test/idle already reached
        jtag_host_model_i.walk(1'b0, 1);
        repeat (40) @(posedge clock);
        chk(WORD_W'(devOperational), '0);
        tally_and_finish;
    end
endmodule // jtag_config_start_sequencer_tb

// [jtag_host_model.sv]
// jtag host model: drives tck, tms and tdi through the tap walks
`timescale 1ns/1ns
module jtag_host_model
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    import cfg_seq_pkg::*;
    ////////////////////////////////////////
    // tck stays low between frames so the device sees no stray edge
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 6 ns tck period; tdo is taken just before the rise, where it has settled
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3 q = tdo;
        tck = 1'b1;
        #3 tck = 1'b0;
    endtask
    // n clocks at one tms level; a released tdi toggles every clock, starting from the inverse of its last bit
    task automatic walk(input logic m, input int n);
        logic q;
        repeat (n) step(m, ~tdi, q);
    endtask
    // from run-test/idle: instruction lsb first, captured value returned, back to idle
    task automatic ir(input logic [IR_LEN-1:0] code, output logic [IR_LEN-1:0] cap);
        walk(1'b1, 2);
        walk(1'b0, 2);
        for (int i = 0; i < IR_LEN; i++)
        begin
            step(i == IR_LEN - 1, code[i], cap[i]);
        end
        walk(1'b1, 1);
        walk(1'b0, 1);
    endtask
    // one configuration word, msb first, then back to run-test/idle
    task automatic dr(input logic [WORD_W-1:0] w);
        logic q;
        walk(1'b1, 1);
        walk(1'b0, 2);
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            step(i == 0, w[i], q);
        end
        walk(1'b1, 1);
        walk(1'b0, 1);
    endtask
endmodule // jtag_host_model
